// >>> logic/cc0_ctrl.sv
// Purpose: CAN control register 0 with AHB-Lite slave and time stamps
// Assumes: status inputs come from logic on clk; can_rx is a pin
// Notes: zero wait states; unmapped words read zero, answer OKAY
// Function
// - Writes only outside init, init request always; status bits read-only
// - Init mode holds register reset, few exceptions
// - Valid received message sets received frame flag
// - Flag cleared by writing one; zero ignored
// - Frame and active flags meaningless in loopback
// - Receiver active follows receiver front end
// - Stop in wait gates bus interface clocks
// - Synchronized bit set and cleared by hardware
// - Timer enable runs 16-bit bit-rate counter
// - Time stamp written to top buffer bytes
// - Disabled timer is cleared to zero
// - Timer enable forced low in init mode
// - Wake-up enable lets bus traffic end sleep
// - Init request answered by init acknowledge
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module cc0_ctrl
   import cc0_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic [1:0] hresp,
   input wire logic frame_rx_valid,
   input wire logic rx_front_active,
   input wire logic bus_synced,
   input wire logic tx_idle,
   input wire logic cpu_wait,
   input wire logic can_rx,
   input wire logic bit_tick,
   input wire logic eof_valid,
   input wire logic eof_is_tx,
   output logic bus_clk_en,
   output logic init_mode_ack,
   output logic sleep_mode_ack,
   output logic wake_restart,
   output logic stamp_we,
   output logic [3:0] stamp_offset,
   output logic [7:0] stamp_byte,
   output logic stamp_is_tx
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   function automatic logic cc0_hit(input logic [7:0] a,
      input logic [7:0] ofs);
      return a == ofs;
   endfunction

   logic received_frame_flag_q, receiver_active_flag_q, stop_in_wait_q;
   logic bus_synchronized_flag_q, timer_en_q, wakeup_enable_q;
   logic sleep_request_q, init_mode_request_q, init_mode_ack_q;
   logic sleep_ack_q, wake_arm_q, wake_q, clk_en_q, ready_q;
   logic [1:0] resp_q;
   logic [31:0] rdata_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic rx_s1_q, rx_s2_q, rx_s3_q;
   cc0_slp_t slp_q;
   logic [7:0] can_control_0, mode_rd, wdat;
   logic addr_phase, wr_ctrl0, init_active, write_ok, rx_fall, wake_hit;

   // Bus side
   assign addr_phase = hsel && hready && htrans[1];
   assign wdat = hwdata[7:0];
   assign wr_ctrl0 = wr_pend_q && cc0_hit(wr_addr_q, CC0_CTRL0_OFS);
   assign init_active = init_mode_request_q && init_mode_ack_q;
   assign write_ok = !init_mode_request_q && !init_mode_ack_q;

   always_comb begin
      can_control_0 = CC0_CTRL0_RST;
      can_control_0[CC0_RECEIVED_FRAME_FLAG_BIT] = received_frame_flag_q;
      can_control_0[CC0_RECEIVER_ACTIVE_FLAG_BIT] = receiver_active_flag_q;
      can_control_0[CC0_CSW_BIT] = stop_in_wait_q;
      can_control_0[CC0_SYNC_BIT] = bus_synchronized_flag_q;
      can_control_0[CC0_TIMER_BIT] = timer_en_q;
      can_control_0[CC0_WAKEUP_ENABLE_BIT] = wakeup_enable_q;
      can_control_0[CC0_SLEEP_REQUEST_BIT] = sleep_request_q;
      can_control_0[CC0_INIT_MODE_REQUEST_BIT] = init_mode_request_q;
      mode_rd = 8'h00;
      mode_rd[CC0_INIT_MODE_ACK_BIT] = init_mode_ack_q;
      mode_rd[CC0_SLPAK_BIT] = sleep_ack_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_phase && hwrite;
         if (addr_phase) begin
            wr_addr_q <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= CC0_RDATA_RST;
         ready_q <= 1'b1;
         resp_q <= CC0_HRESP_OKAY;
      end else begin
         ready_q <= 1'b1;
         resp_q <= CC0_HRESP_OKAY;
         rdata_q <= CC0_RDATA_RST;
         if (addr_phase && !hwrite) begin
            if (cc0_hit(haddr[7:0], CC0_CTRL0_OFS)) begin
               rdata_q <= {24'h00_0000, can_control_0};
            end else if (cc0_hit(haddr[7:0], CC0_MODE_OFS)) begin
               rdata_q <= {24'h00_0000, mode_rd};
            end
         end
      end
   end

   // Received frame flag: hardware set beats software clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         received_frame_flag_q <= 1'b0;
      end else if (init_active) begin
         received_frame_flag_q <= 1'b0;
      end else if (frame_rx_valid) begin
         received_frame_flag_q <= 1'b1;
      end else if (wr_ctrl0 && write_ok && wdat[CC0_RECEIVED_FRAME_FLAG_BIT]) begin
         received_frame_flag_q <= 1'b0;
      end
   end

   // Status bits follow the core; no meaning in loopback
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         receiver_active_flag_q <= 1'b0;
         bus_synchronized_flag_q <= 1'b0;
      end else begin
         receiver_active_flag_q <= rx_front_active && !init_active;
         bus_synchronized_flag_q <= bus_synced && !init_active;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_in_wait_q <= 1'b0;
         timer_en_q <= 1'b0;
      end else if (init_active || init_mode_request_q) begin
         stop_in_wait_q <= init_active ? 1'b0 : stop_in_wait_q;
         timer_en_q <= 1'b0;
      end else if (wr_ctrl0 && write_ok) begin
         stop_in_wait_q <= wdat[CC0_CSW_BIT];
         timer_en_q <= wdat[CC0_TIMER_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wakeup_enable_q <= 1'b0;
      end else if (wr_ctrl0 && write_ok) begin
         wakeup_enable_q <= wdat[CC0_WAKEUP_ENABLE_BIT];
      end
   end

   // Sleep request: cleared by wake, software clear only once asleep
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_request_q <= 1'b0;
      end else if (wake_hit) begin
         sleep_request_q <= 1'b0;
      end else if (wr_ctrl0 && write_ok) begin
         if (wdat[CC0_SLEEP_REQUEST_BIT]) begin
            sleep_request_q <= 1'b1;
         end else if (sleep_ack_q) begin
            sleep_request_q <= 1'b0;
         end
      end
   end

   // Init request writable always; cleared only after acknowledge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         init_mode_request_q <= 1'b0;
      end else if (wr_ctrl0) begin
         if (wdat[CC0_INIT_MODE_REQUEST_BIT]) begin
            init_mode_request_q <= 1'b1;
         end else if (init_mode_ack_q) begin
            init_mode_request_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         init_mode_ack_q <= 1'b0;
      end else begin
         init_mode_ack_q <= init_mode_request_q;
      end
   end

   // Receive pin synchroniser and dominant edge detect
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
         rx_s3_q <= 1'b1;
      end else begin
         rx_s1_q <= can_rx;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
      end
   end

   assign rx_fall = rx_s3_q && !rx_s2_q;
   assign wake_hit = slp_q == CC0_SLEEP && wake_arm_q && rx_fall;

   // Wake-up enable is latched at sleep entry
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slp_q <= CC0_RUN;
         sleep_ack_q <= 1'b0;
         wake_arm_q <= 1'b0;
      end else begin
         case (slp_q)
            CC0_RUN: begin
               sleep_ack_q <= 1'b0;
               if (sleep_request_q && !init_mode_request_q) begin
                  slp_q <= CC0_SLP_WAIT;
               end
            end
            CC0_SLP_WAIT: begin
               if (!sleep_request_q) begin
                  slp_q <= CC0_RUN;
               end else if (!rx_front_active && tx_idle) begin
                  slp_q <= CC0_SLEEP;
                  sleep_ack_q <= 1'b1;
                  wake_arm_q <= wakeup_enable_q;
               end
            end
            CC0_SLEEP: begin
               if (!sleep_request_q) begin
                  slp_q <= CC0_RUN;
                  sleep_ack_q <= 1'b0;
               end
            end
            default: begin
               slp_q <= CC0_RUN;
               sleep_ack_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= wake_hit;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_en_q <= 1'b1;
      end else begin
         clk_en_q <= !(stop_in_wait_q && cpu_wait);
      end
   end

   cc0_ts_if ts ();
   assign ts.timer_en = timer_en_q;
   assign ts.bit_tick = bit_tick;
   assign ts.eof_valid = eof_valid;
   assign ts.eof_is_tx = eof_is_tx;

   cc0_timestamp u_stamp (
      .clk(clk),
      .rst_n(rst_n),
      .ts(ts.stamp)
   );

   assign hreadyout = ready_q;
   assign hrdata = rdata_q;
   assign hresp = resp_q;
   assign bus_clk_en = clk_en_q;
   assign init_mode_ack = init_mode_ack_q;
   assign sleep_mode_ack = sleep_ack_q;
   assign wake_restart = wake_q;
   assign stamp_we = ts.stamp_we;
   assign stamp_offset = ts.stamp_offset;
   assign stamp_byte = ts.stamp_byte;
   assign stamp_is_tx = ts.stamp_is_tx;

   wr_block_a: assert property (
      wr_ctrl0 && !write_ok |=>
      $stable(wakeup_enable_q) && !timer_en_q)
      else $error("control write taken during init");
   init_hold_a: assert property (
      init_active |=> !received_frame_flag_q && !stop_in_wait_q &&
      !receiver_active_flag_q && !bus_synchronized_flag_q)
      else $error("register not held in reset during init");
   frame_set_a: assert property (
      frame_rx_valid && !init_active |=> received_frame_flag_q)
      else $error("received frame flag not set");
   frame_keep_a: assert property (
      received_frame_flag_q && !init_active &&
      !(wr_ctrl0 && wdat[CC0_RECEIVED_FRAME_FLAG_BIT]) |=> received_frame_flag_q)
      else $error("received frame flag lost without clear");
   rx_active_a: assert property (
      !init_active |=> receiver_active_flag_q == $past(rx_front_active))
      else $error("receiver active flag does not track receiver");
   clk_gate_a: assert property (
      stop_in_wait_q && cpu_wait |=> !bus_clk_en)
      else $error("bus clock not gated in wait");
   sync_track_a: assert property (
      !init_active |=> bus_synchronized_flag_q == $past(bus_synced))
      else $error("synchronized flag does not track core");
   timer_init_a: assert property (
      init_mode_request_q |=> !timer_en_q)
      else $error("timer enable set during init");
   wake_clr_a: assert property (
      wake_hit |=> !sleep_request_q && wake_restart ##1 slp_q == CC0_RUN)
      else $error("bus traffic did not end sleep");
   init_ack_a: assert property (
      init_mode_request_q [*2] |-> init_mode_ack)
      else $error("init request not acknowledged");
endmodule // cc0_ctrl

// >>> common/cc0_pkg.sv
// Purpose: shared constants and types of the control register 0 block
// Assumes: one 50 MHz clock, AHB-Lite word access
// Notes: register bits sit in the low byte of each word
package cc0_pkg;
   // Byte addresses of the word registers
   localparam logic [7:0] CC0_CTRL0_OFS = 8'h00;
   localparam logic [7:0] CC0_MODE_OFS = 8'h04;
   // Bit positions in the control register
   localparam int CC0_RECEIVED_FRAME_FLAG_BIT = 7;
   localparam int CC0_RECEIVER_ACTIVE_FLAG_BIT = 6;
   localparam int CC0_CSW_BIT = 5;
   localparam int CC0_SYNC_BIT = 4;
   localparam int CC0_TIMER_BIT = 3;
   localparam int CC0_WAKEUP_ENABLE_BIT = 2;
   localparam int CC0_SLEEP_REQUEST_BIT = 1;
   localparam int CC0_INIT_MODE_REQUEST_BIT = 0;
   // Bit positions in the mode status register
   localparam int CC0_INIT_MODE_ACK_BIT = 0;
   localparam int CC0_SLPAK_BIT = 1;
   // Values after reset
   localparam logic [7:0] CC0_CTRL0_RST = 8'h00;
   localparam logic [15:0] CC0_TS_RST = 16'h0000;
   localparam logic [31:0] CC0_RDATA_RST = 32'h0000_0000;
   // Time stamp byte offsets inside a message buffer
   localparam logic [3:0] CC0_TS_HI_OFS = 4'hE;
   localparam logic [3:0] CC0_TS_LO_OFS = 4'hF;
   localparam logic [1:0] CC0_HRESP_OKAY = 2'h0;
   typedef enum logic [1:0] {
      CC0_RUN = 2'b00,
      CC0_SLP_WAIT = 2'b01,
      CC0_SLEEP = 2'b11
   } cc0_slp_t;
   typedef enum logic [1:0] {
      CC0_TS_IDLE = 2'b00,
      CC0_TS_HI = 2'b01,
      CC0_TS_LO = 2'b11
   } cc0_ts_t;
endpackage

// >>> common/cc0_ts_if.sv
// Purpose: link between the register block and the time stamp unit
// Assumes: both ends on the same clock
// Notes: stamp bytes leave on consecutive cycles
`timescale 1ns/10ps
interface cc0_ts_if;
   logic timer_en;
   logic bit_tick;
   logic eof_valid;
   logic eof_is_tx;
   logic stamp_we;
   logic [3:0] stamp_offset;
   logic [7:0] stamp_byte;
   logic stamp_is_tx;
   modport ctrl (output timer_en, bit_tick, eof_valid, eof_is_tx,
      input stamp_we, stamp_offset, stamp_byte, stamp_is_tx);
   modport stamp (input timer_en, bit_tick, eof_valid, eof_is_tx,
      output stamp_we, stamp_offset, stamp_byte, stamp_is_tx);
endinterface

// >>> logic/cc0_timestamp.sv
// Purpose: 16-bit bit-rate timer and time stamp writer
// Assumes: bit_tick is a one-cycle pulse per CAN bit
// Notes: high byte written first, low byte next cycle
`timescale 1ns/10ps
module cc0_timestamp
   import cc0_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   cc0_ts_if.stamp ts
);
   logic [15:0] count_q;
   logic [7:0] lo_q;
   logic we_q;
   logic [3:0] ofs_q;
   logic [7:0] byte_q;
   logic is_tx_q;
   cc0_ts_t st_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= CC0_TS_RST;
      end else if (!ts.timer_en) begin
         count_q <= CC0_TS_RST;
      end else if (ts.bit_tick) begin
         count_q <= count_q + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= CC0_TS_IDLE;
         lo_q <= 8'h00;
         we_q <= 1'b0;
         ofs_q <= 4'h0;
         byte_q <= 8'h00;
         is_tx_q <= 1'b0;
      end else begin
         we_q <= 1'b0;
         case (st_q)
            CC0_TS_IDLE: begin
               if (ts.eof_valid && ts.timer_en) begin
                  st_q <= CC0_TS_HI;
                  we_q <= 1'b1;
                  ofs_q <= CC0_TS_HI_OFS;
                  byte_q <= count_q[15:8];
                  lo_q <= count_q[7:0];
                  is_tx_q <= ts.eof_is_tx;
               end
            end
            CC0_TS_HI: begin
               st_q <= CC0_TS_LO;
               we_q <= 1'b1;
               ofs_q <= CC0_TS_LO_OFS;
               byte_q <= lo_q;
            end
            default: begin
               st_q <= CC0_TS_IDLE;
            end
         endcase
      end
   end

   assign ts.stamp_we = we_q;
   assign ts.stamp_offset = ofs_q;
   assign ts.stamp_byte = byte_q;
   assign ts.stamp_is_tx = is_tx_q;

   timer_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
      !ts.timer_en |=> count_q == CC0_TS_RST)
      else $error("timer not cleared while disabled");
   timer_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
      ts.timer_en && ts.bit_tick |=> count_q == 16'($past(count_q) + 1))
      else $error("timer did not advance on bit tick");
   stamp_seq_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == CC0_TS_IDLE && ts.eof_valid && ts.timer_en |=>
      we_q && ofs_q == CC0_TS_HI_OFS && byte_q == $past(count_q[15:8])
      ##1 we_q && ofs_q == CC0_TS_LO_OFS)
      else $error("time stamp bytes not written in order");
endmodule // cc0_timestamp

// >>> test/cc0_can_side.sv
// Purpose: CAN side stand-in making bit ticks and receive pin activity
// Assumes: commanded by the bench on clk
// Notes: receive pin idles recessive (1), dominant burst on wake_go
`timescale 1ns/10ps
module cc0_can_side (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick_run,
   input wire logic wake_go,
   output logic bit_tick,
   output logic can_rx
);
   logic [1:0] div_q;
   logic [3:0] dom_q;
   // One tick every four cycles while running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 2'h0;
         bit_tick <= 1'b0;
      end else begin
         div_q <= tick_run ? div_q + 2'h1 : 2'h0;
         bit_tick <= tick_run && (div_q == 2'h3);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dom_q <= 4'h0;
      end else if (wake_go) begin
         dom_q <= 4'hF;
      end else if (dom_q != 4'h0) begin
         dom_q <= dom_q - 4'h1;
      end
   end
   assign can_rx = (dom_q == 4'h0);
endmodule // cc0_can_side

// >>> test/tb.sv
// Purpose: self-checking bench of control register 0
// Assumes: AHB-Lite master in the bench, CAN side stand-in
// Notes: each scenario task drives and judges on its own
`timescale 1ns/10ps
module tb
   import cc0_pkg::*;
;
   logic clk, rst_n, hsel, hwrite, frame_rx_valid, rx_front_active;
   logic bus_synced, tx_idle, cpu_wait, eof_valid, eof_is_tx;
   logic tick_run, wake_go, hreadyout, bit_tick, can_rx, bus_clk_en;
   logic init_mode_ack, sleep_mode_ack, wake_restart, stamp_we;
   logic stamp_is_tx;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, hresp;
   logic [2:0] hsize;
   logic [3:0] stamp_offset;
   logic [7:0] stamp_byte;
   wire hready = hreadyout;
   int n_errors = 0;
   int compares = 0;

   cc0_ctrl DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .frame_rx_valid(frame_rx_valid),
      .rx_front_active(rx_front_active), .bus_synced(bus_synced),
      .tx_idle(tx_idle), .cpu_wait(cpu_wait), .can_rx(can_rx),
      .bit_tick(bit_tick), .eof_valid(eof_valid), .eof_is_tx(eof_is_tx),
      .bus_clk_en(bus_clk_en), .init_mode_ack(init_mode_ack),
      .sleep_mode_ack(sleep_mode_ack), .wake_restart(wake_restart),
      .stamp_we(stamp_we), .stamp_offset(stamp_offset),
      .stamp_byte(stamp_byte), .stamp_is_tx(stamp_is_tx));
   cc0_can_side can_side (.clk(clk), .rst_n(rst_n), .tick_run(tick_run),
      .wake_go(wake_go), .bit_tick(bit_tick), .can_rx(can_rx));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic end_of_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // sel 0 sleep ack, 1 wake pulse, 2 stamp write
   task automatic wait_for(input int sel, input logic lvl, input int lim,
      input logic must, output logic got);
      got = 1'b0;
      for (int n = 0; n < lim && !got; n++) begin
         @(posedge clk);
         got = ((sel == 0) ? sleep_mode_ack :
            (sel == 1) ? wake_restart : stamp_we) === lvl;
      end
      if (must && !got) begin
         n_errors++;
         $display("CHECK FAILED wait %0d expected %b seen %b", sel, lvl, ~lvl);
         end_of_test();
      end
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED hready expected 1 seen %b", hready);
         end_of_test();
      end
   endtask

   task automatic bus_op(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      hsize <= 3'b010;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      check("hresp", {30'h0, hresp}, {30'h0, CC0_HRESP_OKAY});
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] rd;
      bus_op(1'b1, a, {24'h000000, d}, rd);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a,
      input logic [7:0] exp);
      logic [31:0] rd;
      bus_op(1'b0, a, 32'hA5A5_5A5A, rd);
      check(what, rd, {24'h000000, exp});
   endtask

   task automatic pulse_frame();
      frame_rx_valid <= 1'b1;
      @(posedge clk);
      frame_rx_valid <= 1'b0;
      @(posedge clk);
   endtask

   task automatic eof_stamp(input logic tx, input logic [15:0] exp);
      logic got;
      eof_is_tx <= tx;
      eof_valid <= 1'b1;
      @(posedge clk);
      eof_valid <= 1'b0;
      wait_for(2, 1'b1, 20, 1'b1, got);
      check("stamp hi", {stamp_offset, stamp_byte},
         {4'hE, exp[15:8]});
      check("stamp tx", stamp_is_tx, tx);
      @(posedge clk);
      check("stamp lo", {stamp_we, stamp_offset, stamp_byte},
         {1'b1, 4'hF, exp[7:0]});
   endtask

   task automatic t_reset();
      rd_chk("ctrl rst", CC0_CTRL0_OFS, CC0_CTRL0_RST);
      rd_chk("mode rst", CC0_MODE_OFS, 8'h00);
      wr(8'h08, 8'hFF);
      rd_chk("unmapped", 8'h08, 8'h00);
      check("clk en rst", bus_clk_en, 1'b1);
   endtask

   task automatic t_status();
      rx_front_active <= 1'b1;
      bus_synced <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk("status on", CC0_CTRL0_OFS, 8'h50);
      rx_front_active <= 1'b0;
      bus_synced <= 1'b0;
      wr(CC0_CTRL0_OFS, 8'h50);
      rd_chk("status ro", CC0_CTRL0_OFS, 8'h00);
   endtask

   task automatic t_frame();
      pulse_frame();
      rd_chk("frame set", CC0_CTRL0_OFS, 8'h80);
      wr(CC0_CTRL0_OFS, 8'h00);
      rd_chk("frame w0", CC0_CTRL0_OFS, 8'h80);
      wr(CC0_CTRL0_OFS, 8'h80);
      rd_chk("frame w1c", CC0_CTRL0_OFS, 8'h00);
   endtask

   task automatic t_wait();
      wr(CC0_CTRL0_OFS, 8'h20);
      cpu_wait <= 1'b1;
      repeat (3) @(posedge clk);
      check("gate on", bus_clk_en, 1'b0);
      cpu_wait <= 1'b0;
      repeat (3) @(posedge clk);
      check("gate off", bus_clk_en, 1'b1);
      wr(CC0_CTRL0_OFS, 8'h00);
      cpu_wait <= 1'b1;
      repeat (3) @(posedge clk);
      check("no gate", bus_clk_en, 1'b1);
      cpu_wait <= 1'b0;
   endtask

   task automatic t_timer();
      logic [15:0] cnt;
      logic got;
      cnt = 16'h0000;
      wr(CC0_CTRL0_OFS, 8'h08);
      tick_run <= 1'b1;
      for (int i = 0; i < 44; i++) begin
         @(posedge clk);
         if (i == 40) begin
            tick_run <= 1'b0;
         end
         if (bit_tick === 1'b1) begin
            cnt = cnt + 16'h0001;
         end
      end
      eof_stamp(1'b1, cnt);
      wr(CC0_CTRL0_OFS, 8'h00);
      wr(CC0_CTRL0_OFS, 8'h08);
      eof_stamp(1'b0, 16'h0000);
      wr(CC0_CTRL0_OFS, 8'h00);
      eof_valid <= 1'b1;
      @(posedge clk);
      eof_valid <= 1'b0;
      wait_for(2, 1'b1, 5, 1'b0, got);
      check("no stamp", got, 1'b0);
   endtask

   task automatic t_init();
      wr(CC0_CTRL0_OFS, 8'h2D);
      rx_front_active <= 1'b1;
      pulse_frame();
      rd_chk("init hold", CC0_CTRL0_OFS, 8'h05);
      rd_chk("init ack", CC0_MODE_OFS, 8'h01);
      check("ack pin", init_mode_ack, 1'b1);
      cpu_wait <= 1'b1;
      repeat (3) @(posedge clk);
      check("init gate", bus_clk_en, 1'b1);
      cpu_wait <= 1'b0;
      rx_front_active <= 1'b0;
      wr(CC0_CTRL0_OFS, 8'h29);
      rd_chk("init wr", CC0_CTRL0_OFS, 8'h05);
      wr(CC0_CTRL0_OFS, 8'h04);
      repeat (2) @(posedge clk);
      rd_chk("init exit", CC0_MODE_OFS, 8'h00);
      wr(CC0_CTRL0_OFS, 8'h0C);
      rd_chk("wr again", CC0_CTRL0_OFS, 8'h0C);
      wr(CC0_CTRL0_OFS, 8'h04);
   endtask

   task automatic t_sleep();
      logic got;
      wr(CC0_CTRL0_OFS, 8'h06);
      wait_for(0, 1'b1, 40, 1'b1, got);
      wake_go <= 1'b1;
      @(posedge clk);
      wake_go <= 1'b0;
      wait_for(1, 1'b1, 30, 1'b0, got);
      check("wake", got, 1'b1);
      repeat (3) @(posedge clk);
      check("awake", sleep_mode_ack, 1'b0);
      rd_chk("rq cleared", CC0_CTRL0_OFS, 8'h04);
      wr(CC0_CTRL0_OFS, 8'h00);
      wr(CC0_CTRL0_OFS, 8'h02);
      wait_for(0, 1'b1, 40, 1'b1, got);
      wake_go <= 1'b1;
      @(posedge clk);
      wake_go <= 1'b0;
      wait_for(1, 1'b1, 30, 1'b0, got);
      check("no wake", {got, sleep_mode_ack}, 2'b01);
      wr(CC0_CTRL0_OFS, 8'h00);
      wait_for(0, 1'b0, 20, 1'b1, got);
   endtask

   task automatic t_rst_mid();
      wr(CC0_CTRL0_OFS, 8'h2C);
      pulse_frame();
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("rst pins", {bus_clk_en, init_mode_ack, sleep_mode_ack},
         3'b100);
      rd_chk("rst ctrl", CC0_CTRL0_OFS, CC0_CTRL0_RST);
   endtask

   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      frame_rx_valid = 1'b0;
      rx_front_active = 1'b0;
      bus_synced = 1'b0;
      tx_idle = 1'b1;
      cpu_wait = 1'b0;
      eof_valid = 1'b0;
      eof_is_tx = 1'b0;
      tick_run = 1'b0;
      wake_go = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_status();
      t_frame();
      t_wait();
      t_timer();
      t_init();
      t_sleep();
      t_rst_mid();
      end_of_test();
   end
endmodule // tb
